/* rtl/rbl_bus_ctrl.v */
// Purpose: Register bus controller between core and peripheral registers, with lockout
// Assumes: Requests synchronous to clk; peripherals sample rd/wr strobes on last bus cycle
// Notes:   Also holds a generic per-flag lockout mask that peripherals may instance
//          Byte requests always finish three edges after they are taken
`timescale 1ns/100ps
`include "rbl_defs.vh"

module rbl_bus_ctrl #(
  parameter AW = `RBL_ADDR_W
) (
  // Clock and reset
  input  wire          clk,
  input  wire          sys_rst,
  // Core request side
  input  wire          req_valid,
  input  wire          req_write,
  input  wire          req_wide,
  input  wire [1:0]    req_op,
  input  wire          req_last,
  input  wire [AW-1:0] req_addr,
  input  wire [15:0]   req_wdata,
  output reg           core_stall,
  output reg           rsp_valid,
  output reg  [15:0]   rsp_rdata,
  // Register bus side
  output reg  [AW-1:0] bus_addr,
  output reg  [7:0]    bus_wdata,
  output reg           bus_rd,
  output reg           bus_wr,
  input  wire [7:0]    bus_rdata,
  output reg           rmw_active
);

  // One-hot sequencer states
  localparam ST_IDLE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_XFER = 3'h4;

  // Sequencer state and beat counter
  reg [2:0]    state_q;
  reg [1:0]    cyc_q;

  // Request held for the whole transfer, while core_stall holds the core off
  reg          hi_q;
  reg          wide_q;
  reg          write_q;
  reg [15:0]   wdata_q;

  // Lockout bookkeeping
  reg          in_rmw_q;
  reg          end_rmw_q;

  // Request decode
  wire         is_rmw;
  wire         take;
  wire         rmw_open;
  wire         last_beat;

  assign is_rmw = (req_op == `RBL_OP_BIT) || (req_op == `RBL_OP_MODIFY);
  // Requests are taken only while idle, so a busy bus holds the core off
  assign take   = req_valid && state_q[0];
  // A modify read that opens a new lock; it must beat a lock closing at the same edge
  assign rmw_open = take && is_rmw && !req_write;
  // Second beat of a transfer, where read data is sampled and strobes drop
  assign last_beat = (cyc_q == (`RBL_XFER_CYC - 2'h1));

  // Transfer sequencer; a new request always sits one wait cycle, so 3 clocks per byte
  always @(posedge clk) begin
    if (sys_rst) begin
      // Everything idle and every output low while in reset
      state_q    <= ST_IDLE;
      cyc_q      <= 2'h0;
      hi_q       <= 1'b0;
      wide_q     <= 1'b0;
      write_q    <= 1'b0;
      wdata_q    <= 16'h0000;
      bus_addr   <= {AW{1'b0}};
      bus_wdata  <= 8'h00;
      bus_rd     <= 1'b0;
      bus_wr     <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_rdata  <= 16'h0000;
      core_stall <= 1'b0;
      in_rmw_q   <= 1'b0;
      end_rmw_q  <= 1'b0;
      rmw_active <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      end_rmw_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Latch the request and start holding the core off
          if (take) begin
            write_q    <= req_write;
            wide_q     <= req_wide;
            wdata_q    <= req_wdata;
            bus_addr   <= req_addr;
            hi_q       <= 1'b0;
            core_stall <= 1'b1;
            state_q    <= ST_WAIT;
            if (is_rmw) begin
              in_rmw_q <= 1'b1;
            end
            if (rmw_open) begin
              rmw_active <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // Fixed one-cycle start delay, then both strobe beats
          cyc_q     <= 2'h0;
          bus_rd    <= !write_q;
          bus_wr    <= write_q;
          bus_wdata <= hi_q ? wdata_q[15:8] : wdata_q[7:0];
          state_q   <= ST_XFER;
        end
        ST_XFER: begin
          // Strobes stand for exactly two beats
          cyc_q <= cyc_q + 2'h1;
          if (last_beat) begin
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            // Read data is taken while the read strobe still stands
            if (!write_q) begin
              if (hi_q) begin
                rsp_rdata[15:8] <= bus_rdata;
              end else begin
                rsp_rdata <= {8'h00, bus_rdata};
              end
            end
            // Low half done: go back for the high byte at the next address
            if (wide_q && !hi_q) begin
              hi_q     <= 1'b1;
              bus_addr <= bus_addr + `RBL_ADDR_INC;
              state_q  <= ST_WAIT;
            end else begin
              rsp_valid  <= 1'b1;
              core_stall <= 1'b0;
              state_q    <= ST_IDLE;
              // Write-back of the modify has landed; the lock closes next edge
              if (write_q && in_rmw_q && req_last) begin
                in_rmw_q  <= 1'b0;
                end_rmw_q <= 1'b1;
              end
            end
          end
        end
        // Recover from an illegal state code
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Indication drops once the write-back of the modify has landed
      // A lock opened at that same edge is kept, else its flags go unprotected
      if (end_rmw_q && !rmw_open) begin
        rmw_active <= 1'b0;
      end
    end
  end

endmodule

// Per-flag lockout mask for a peripheral status register
module rbl_flag_guard #(
  parameter W = `RBL_DATA_W
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Lockout indication from controller
  input  wire         rmw_active,
  // Peripheral flag updates and core write
  input  wire [W-1:0] hw_set,
  input  wire         cpu_wr,
  input  wire [W-1:0] cpu_wdata,
  output reg  [W-1:0] flags_q
);

  // Per-flag record of updates and edge detect of the indication
  reg  [W-1:0] touched_q;
  reg          rmw_dly_q;
  wire         rmw_start;

  // One-cycle pulse when a new modify opens
  assign rmw_start = rmw_active && !rmw_dly_q;

  // One lockout cell per flag bit
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Hardware set wins over a core write in the same cycle
      always @(posedge clk) begin
        if (sys_rst) begin
          flags_q[i]   <= 1'b0;
          touched_q[i] <= 1'b0;
        end else begin
          if (hw_set[i]) begin
            flags_q[i] <= 1'b1;
          end else if (cpu_wr && !(rmw_active && touched_q[i])) begin
            flags_q[i] <= cpu_wdata[i];
          end
          // Record: loaded at modify start, grows during it, empty outside
          if (rmw_start) begin
            touched_q[i] <= hw_set[i];
          end else if (rmw_active && hw_set[i]) begin
            touched_q[i] <= 1'b1;
          end else if (!rmw_active) begin
            touched_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Edge detector for start of a new modify
  always @(posedge clk) begin
    if (sys_rst) begin
      rmw_dly_q <= 1'b0;
    end else begin
      rmw_dly_q <= rmw_active;
    end
  end

endmodule

/* rtl/rbl_defs.vh */
// Purpose: Constants for the peripheral register bus controller with modify lockout
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes:   Plain Verilog header, definitions only
// How it works
// - Controller is its own block; an accepted write finishes while the core continues. The code stalls the core until every request, writes included, finishes.
// - A request made while the controller is busy is stalled until it frees.
// - Each read or write occupies the register bus for exactly two clocks.
// - Transfer starts zero or one clock after request; completion after two or three. The code always starts one clock after and completes after three.
// - Register bus data path is eight bits wide, byte transfers only.
// - A 16-bit request is split into two consecutive byte transfers, low byte first.
// - Bit writes and whole-register modifies count as read-modify-write, plain moves not.
// - A lockout indication goes to all peripherals while the modify is in progress.
// - Peripheral blocks write-back only to flags it updated since the modify began.
// - After the modify ends, a core write may change every bit again.
// - All peripheral and status-word registers are read and written through this bus.
`ifndef RBL_DEFS_VH
`define RBL_DEFS_VH
`define RBL_DATA_W    8
`define RBL_ADDR_W    11
`define RBL_XFER_CYC  2'h2
`define RBL_ADDR_INC  11'h001
`define RBL_OP_MOVE   2'h0
`define RBL_OP_BIT    2'h1
`define RBL_OP_MODIFY 2'h2
`endif

/* sim/peripheral_register_bus_lockout_tb.sv */
// Purpose: Self-checking bench
// Assumes: 5 ns clock
// Notes:   Byte model in an int array
`timescale 1ns/100ps
module peripheral_register_bus_lockout_tb;
  reg         clk, sys_rst, req_valid, req_write, req_wide, req_last;
  reg  [1:0]  req_op;
  reg  [10:0] req_addr;
  reg  [15:0] req_wdata;
  reg  [7:0]  hw_set;
  wire        core_stall, rsp_valid, bus_rd, bus_wr, rmw_active;
  wire [15:0] rsp_rdata;
  wire [10:0] bus_addr;
  wire [7:0]  bus_wdata, bus_rdata;
  integer     fail_count, comparisons, seed, i, a, n;
  integer     mdl [0:15];
  rbl_bus_ctrl i_rbl_bus_ctrl (.clk, .sys_rst, .req_valid, .req_write, .req_wide, .req_op,
    .req_last, .req_addr, .req_wdata, .core_stall, .rsp_valid, .rsp_rdata, .bus_addr,
    .bus_wdata, .bus_rd, .bus_wr, .bus_rdata, .rmw_active);
  rbl_periph i_rbl_periph (.clk, .sys_rst, .bus_addr, .bus_wdata, .bus_rd, .bus_wr,
    .rmw_active, .hw_set, .bus_rdata);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task give_verdict;
    begin
      $display("checks %0d errors %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input integer exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp[15:0]) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp[15:0]);
      end
    end
  endtask
  // Hold one request until answered; bounded wait
  task xfer(input w, input wd, input [1:0] op, input lst, input [10:0] ad, input [15:0] d);
    begin
      {req_valid, req_write, req_wide, req_op, req_last} = {1'b1, w, wd, op, lst};
      {req_addr, req_wdata} = {ad, d};
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n = n + 1;
      end while (rsp_valid !== 1'b1 && n < 20);
      if (n >= 20) begin
        chk(16'hXXXX, 0);
        give_verdict;
      end else begin
        chk(wd ? (n >= 5 && n <= 7) : (n >= 3 && n <= 4), 1);
      end
    end
  endtask
  initial begin
    {seed, fail_count, comparisons} = {32'h1904, 64'h0};
    {sys_rst, req_valid, req_write, req_wide, req_op, req_last} = 7'h40;
    {req_addr, req_wdata, hw_set} = 35'h0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    // Back-to-back writes then reads
    for (i = 0; i < 15; i = i + 1) begin
      mdl[i] = $random(seed) & 255;
      xfer(1, 0, 0, 0, i, mdl[i]);
    end
    for (i = 0; i < 15; i = i + 1) begin
      xfer(0, 0, 0, 0, i, 0);
      chk(rsp_rdata[7:0], mdl[i]);
    end
    chk(rmw_active, 0);
    a = $random(seed) & 65535;
    xfer(1, 1, 0, 0, 4, a);
    xfer(0, 1, 0, 0, 4, 0);
    chk(rsp_rdata, a);
    xfer(0, 0, 0, 0, 5, 0);
    chk(rsp_rdata[7:0], a >> 8);
    // Hardware flag set inside a modify survives write-back
    xfer(1, 0, 0, 0, 15, 16'hF0);
    xfer(0, 0, 2, 0, 15, 0);
    chk(rsp_rdata[7:0], 'hF0);
    chk(rmw_active, 1);
    req_valid = 0;
    hw_set = 8'h01;
    @(posedge clk) #1 hw_set = 0;
    xfer(1, 0, 2, 1, 15, 0);
    xfer(0, 0, 0, 0, 15, 0);
    chk(rsp_rdata[7:0], 'h01);
    chk(rmw_active, 0);
    xfer(0, 0, 1, 0, 15, 0);
    xfer(1, 0, 1, 1, 15, 0);
    req_valid = 0;
    repeat (4) @(posedge clk);
    #1 xfer(0, 0, 0, 0, 15, 0);
    chk(rsp_rdata[7:0], 0);
    req_valid = 0;
    repeat (4) @(posedge clk);
    give_verdict;
  end
endmodule

/* sim/rbl_chk_checker.sv */
// Purpose: Port assertions for the bus controller
// Assumes: One clock, sync reset
// Notes:   Bound to every controller
`timescale 1ns/100ps
module rbl_chk (
  // Watched ports
  input wire       clk,
  input wire       sys_rst,
  input wire       req_valid,
  input wire       req_write,
  input wire       req_wide,
  input wire [1:0] req_op,
  input wire       req_last,
  input wire       core_stall,
  input wire       rsp_valid,
  input wire       bus_rd,
  input wire       bus_wr,
  input wire       rmw_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Request taken
  wire tk = req_valid && !core_stall;
  property p_rd; $rose(bus_rd) |=> bus_rd ##1 !bus_rd; endproperty
  a_rd: assert property (p_rd) else $error("rd width");
  property p_wr; $rose(bus_wr) |=> bus_wr ##1 !bus_wr; endproperty
  a_wr: assert property (p_wr) else $error("wr width");
  property p_ans; tk |-> ##[2:8] rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("late");
  property p_lat; tk && !req_wide |-> ##4 rsp_valid; endproperty
  a_lat: assert property (p_lat) else $error("byte latency");
  property p_wlat; tk && req_wide |-> ##7 rsp_valid; endproperty
  a_wlat: assert property (p_wlat) else $error("wide latency");
  property p_stl; tk |=> core_stall; endproperty
  a_stl: assert property (p_stl) else $error("no stall");
  property p_rsp; rsp_valid |-> $fell(bus_rd) || $fell(bus_wr); endproperty
  a_rsp: assert property (p_rsp) else $error("no transfer");
  property p_rmw; $rose(rmw_active) |-> $past(tk) && $past(req_op) != 2'h0; endproperty
  a_rmw: assert property (p_rmw) else $error("bad lock");
  property p_mov; tk && req_op == 2'h0 && !rmw_active |=> !rmw_active; endproperty
  a_mov: assert property (p_mov) else $error("move locked");
  property p_end; tk && rmw_active && req_write && req_last |-> ##[3:8] !rmw_active; endproperty
  a_end: assert property (p_end) else $error("lock stuck");
  cover property (tk && req_write);
  cover property ($rose(rmw_active));
  cover property ($fell(rmw_active));
endmodule
bind rbl_bus_ctrl rbl_chk i_rbl_chk (.clk, .sys_rst, .req_valid, .req_write, .req_wide, .req_op,
  .req_last, .core_stall, .rsp_valid, .bus_rd, .bus_wr, .rmw_active);

/* sim/rbl_periph.sv */
// Purpose: Peripheral register model
// Assumes: Address bits 3:0; register 15 holds flags
// Notes:   Idle read data is inverted so stale bytes never match
`timescale 1ns/100ps
module rbl_periph (
  // Bus and flag inputs
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [10:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_rd,
  input  wire        bus_wr,
  input  wire        rmw_active,
  input  wire [7:0]  hw_set,
  // Read data
  output wire [7:0]  bus_rdata
);
  reg  [7:0] mem_q [0:15];
  reg  [7:0] last_q;
  wire [7:0] stat;
  wire [7:0] sel = (bus_addr[3:0] == 4'hF) ? stat : mem_q[bus_addr[3:0]];
  // Flags with lockout
  rbl_flag_guard i_rbl_flag_guard (.clk(clk), .sys_rst(sys_rst), .rmw_active(rmw_active),
    .hw_set(hw_set), .cpu_wr(bus_wr && bus_addr[3:0] == 4'hF), .cpu_wdata(bus_wdata),
    .flags_q(stat));
  // Byte store
  always @(posedge clk) begin
    if (bus_wr) begin
      mem_q[bus_addr[3:0]] <= bus_wdata;
    end
    if (bus_rd) begin
      last_q <= sel;
    end
  end
  assign bus_rdata = bus_rd ? sel : ~last_q;
endmodule
